// File: flash_boot_checker.sv
// Purpose: concurrent checks on the ports of the flash sequencer control block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   an operation lasts a fixed ten cycles unless a sequencer reset cuts it short
`include "flash_seq_params.svh"
module flash_boot_checker (
    input wire logic                    clk, reset_n, seq_reset, dual_mode,
    input wire logic                    write_protect_window, toggle_region_swap_flag,
    input wire logic                    toggle_startup_bank, write_region_select,
    input wire logic [1:0]              region_select_in, read_region_select,
    input wire logic                    write_clock_freq, fast_data_read,
    input wire logic [`FREQ_W-1:0]      clock_freq_hz, flash_clock_hz,
    input wire flash_seq_pkg::window_t  window_in, read_protect_window,
    input wire flash_seq_pkg::pe_req_t  pe_req,
    input wire logic                    sequencer_idle, flash_ready_irq, window_active,
    input wire logic                    pe_refused, pe_start
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Any higher-priority command masks a program or erase request
    wire other_cmd = seq_reset | write_protect_window | toggle_region_swap_flag
                   | toggle_startup_bank;
    wire take_win  = write_protect_window && sequencer_idle && !seq_reset;
    wire pe_take   = pe_req.valid && sequencer_idle && !other_cmd && window_active;
    wire in_win    = pe_req.blk >= read_protect_window.start_blk
                   && pe_req.blk < read_protect_window.end_blk;
    wire same_ends = window_in.start_blk == window_in.end_blk;
    logic [3:0]             age_ff;
    logic                   cap_same_ff;
    flash_seq_pkg::window_t cap_win_ff;
    // Counts edges since an accepted window write; a sequencer reset drops the count
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            age_ff      <= 4'h0;
            cap_same_ff <= 1'b0;
            cap_win_ff  <= '0;
        end else if (take_win) begin
            age_ff      <= 4'h1;
            cap_same_ff <= same_ends;
            cap_win_ff  <= window_in;
        end else if (seq_reset || age_ff == 4'hA) begin
            age_ff      <= 4'h0;
        end else if (age_ff != 4'h0) begin
            age_ff      <= age_ff + 4'h1;
        end
    end

    busy_rise_a: assert property (take_win |=> !sequencer_idle)
        else $error("sequencer stayed idle after a window write");
    ready_time_a: assert property (age_ff == 4'hA |-> flash_ready_irq)
        else $error("ready pulse missing ten cycles after window write");
    ready_idle_a: assert property (flash_ready_irq |-> sequencer_idle && $past(!sequencer_idle))
        else $error("ready pulse not at the end of a busy interval");
    seq_abort_a: assert property (seq_reset |=> sequencer_idle)
        else $error("sequencer reset did not return to idle");
    pe_refuse_a: assert property (pe_take && !in_win |=> pe_refused && !pe_start)
        else $error("request outside window not refused");
    pe_accept_a: assert property (pe_take && in_win |=> pe_start && !pe_refused)
        else $error("request inside window not accepted");
    win_clear_a: assert property (age_ff == 4'hA && cap_same_ff |-> !window_active)
        else $error("equal window ends did not remove the window");
    win_load_a: assert property (age_ff == 4'hA && !cap_same_ff |->
        read_protect_window == cap_win_ff && window_active)
        else $error("window readback differs from written window");
    freq_load_a: assert property (write_clock_freq |=> flash_clock_hz == $past(clock_freq_hz)
        && fast_data_read == ($past(clock_freq_hz) > `FAST_READ_THRESH_HZ))
        else $error("clock frequency or read speed not updated");
    sel_load_a: assert property (write_region_select && !dual_mode && region_select_in != 2'h3
        |=> read_region_select == $past(region_select_in))
        else $error("region select write not applied at once");
endmodule

// File: flash_seq_params.svh
// Purpose: constants for the flash sequencer control block
// Assumes: 25 MHz clk
// Notes:   timing counts are derived from times in ns
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH

`define CLK_PERIOD_NS        40
`define OP_TIME_NS           400
`define OP_CYCLES            ((`OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLK_W                8
`define FREQ_W               32
`define SEL_FOLLOW           2'h0
`define SEL_ZERO             2'h1
`define SEL_ONE              2'h2
`define BANK_ZERO_CODE       1'h1
`define BANK_ONE_CODE        1'h0
`define SWAP_FLAG_RESET      1'h1
`define BANK_SEL_RESET       1'h0
`define FAST_READ_MHZ_LIMIT  32'h0000_0000
`define FAST_READ_THRESH_HZ  32'h01C9_C380

`endif

// File: flash_seq_pkg.sv
// Purpose: types for the flash sequencer control block
// Assumes: flash_seq_params.svh supplies widths
// Notes:   none
`include "flash_seq_params.svh"
package flash_seq_pkg;
    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_WINDOW  = 4'h2,
        ST_SWAP    = 4'h4,
        ST_PROGRAM = 4'h8
    } seq_state_t;

    typedef struct packed {
        logic [`BLK_W-1:0] start_blk;
        logic [`BLK_W-1:0] end_blk;
    } window_t;

    typedef struct packed {
        logic              valid;
        logic              erase;
        logic [`BLK_W-1:0] blk;
    } pe_req_t;
endpackage

// File: flash_sequencer_boot_control.sv
// Purpose: control part of an on-chip flash sequencer: busy state, access
//          window, startup-region swap and select, startup bank readback
// Assumes: all inputs synchronous to clk; commands are one-cycle pulses
// Notes:   the program/erase algorithm itself is outside; an accepted
//          operation is modelled as a fixed busy interval
// Overview of operation
// - Bank readback: bank zero 1, one 0
// - Busy/idle readable at any time
// - Sequencer reset accepted any time, returns idle
// - Access window start and end readable
// - Refuse program/erase outside access window
// - Only one access window range exists
// - Equal start and end removes window
// - Ready pulse after window written
// - Swap flag: 0 swapped, 1 default
// - Swap toggle effective after next reset
// - Ready pulse after swap flag toggled
// - Select: follow flag, region 0, region 1
// - Select immediate; resets to follow flag
`include "flash_seq_params.svh"
module flash_sequencer_boot_control (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    dual_mode,
    input  wire logic                    seq_reset,
    input  wire logic                    write_protect_window,
    input  wire flash_seq_pkg::window_t  window_in,
    input  wire logic                    toggle_region_swap_flag,
    input  wire logic                    write_region_select,
    input  wire logic [1:0]              region_select_in,
    input  wire logic                    toggle_startup_bank,
    input  wire logic                    write_clock_freq,
    input  wire logic [`FREQ_W-1:0]      clock_freq_hz,
    input  wire flash_seq_pkg::pe_req_t  pe_req,
    output logic                         sequencer_idle,
    output logic                         flash_ready_irq,
    output flash_seq_pkg::window_t       read_protect_window,
    output logic                         window_active,
    output logic                         pe_refused,
    output logic                         pe_start,
    output logic                         read_region_swap_flag,
    output logic [1:0]                   read_region_select,
    output logic                         active_startup_region,
    output logic                         read_startup_bank,
    output logic                         fast_data_read,
    output logic [`FREQ_W-1:0]           flash_clock_hz
);
    flash_seq_pkg::seq_state_t state_ff, nxt_state;
    logic [7:0]              cnt_ff, nxt_cnt;
    flash_seq_pkg::window_t  win_ff, nxt_win, pend_win_ff;
    logic                    win_on_ff, pend_on_ff;
    // Stored (nonvolatile-like) swap flag and the copy in force since reset
    // Nonvolatile bits power up in their erased state and ignore system reset
    logic                    swap_store_ff = `SWAP_FLAG_RESET;
    logic                    swap_live_ff;
    logic                    live_loaded_ff;
    logic [1:0]              sel_ff;
    logic                    bank_store_ff = `BANK_SEL_RESET;
    logic                    toggle_pend_region_ff;
    logic                    region_now_ff;
    logic                    bank_live_ff;
    logic                    ready_ff, idle_ff, refused_ff, start_ff;
    logic [`FREQ_W-1:0]      freq_ff;
    logic                    fast_ff;

    wire idle_now = (state_ff == flash_seq_pkg::ST_IDLE);
    wire done_now = !idle_now && (cnt_ff == 8'h00);
    wire in_win   = !win_on_ff ||
                    (pe_req.blk >= win_ff.start_blk && pe_req.blk < win_ff.end_blk);
    wire pe_ok    = pe_req.valid && idle_now && in_win;
    wire pe_bad   = pe_req.valid && !in_win;
    wire go_win   = idle_now && write_protect_window;
    wire go_swap  = idle_now && (toggle_region_swap_flag || (toggle_startup_bank && dual_mode));

    // One command at a time; while busy, window writes, swap toggles and program/erase starts are ignored, but a sequencer reset is not
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00;
        if (seq_reset) begin
            nxt_state = flash_seq_pkg::ST_IDLE;
            nxt_cnt   = 8'h00;
        end else if (done_now) begin
            nxt_state = flash_seq_pkg::ST_IDLE;
        end else if (go_win) begin
            // Ready lands OP_CYCLES edges after the take: one for busy, one for done
            nxt_state = flash_seq_pkg::ST_WINDOW;
            nxt_cnt   = 8'(`OP_CYCLES - 2);
        end else if (go_swap) begin
            nxt_state = flash_seq_pkg::ST_SWAP;
            nxt_cnt   = 8'(`OP_CYCLES - 2);
        end else if (pe_ok) begin
            nxt_state = flash_seq_pkg::ST_PROGRAM;
            nxt_cnt   = 8'(`OP_CYCLES - 2);
        end
    end

    // A single window register; equal bounds remove it
    always_comb begin
        nxt_win = pend_win_ff;
        if (go_win && !seq_reset)
            nxt_win = window_in;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= flash_seq_pkg::ST_IDLE;
            cnt_ff   <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // Window takes effect when its write operation completes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_win_ff <= '0;
            pend_on_ff  <= 1'b0;
            win_ff      <= '0;
            win_on_ff   <= 1'b0;
        end else begin
            pend_win_ff <= nxt_win;
            if (go_win && !seq_reset)
                pend_on_ff <= (window_in.start_blk != window_in.end_blk);
            if (done_now && state_ff == flash_seq_pkg::ST_WINDOW && !seq_reset) begin
                win_ff    <= pend_win_ff;
                win_on_ff <= pend_on_ff;
            end
        end
    end

    // Stored flag changes now; the live copy is only reloaded after reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            live_loaded_ff <= 1'b0;
            swap_live_ff   <= `SWAP_FLAG_RESET;
            bank_live_ff   <= `BANK_SEL_RESET;
        end else if (!live_loaded_ff) begin
            live_loaded_ff <= 1'b1;
            swap_live_ff   <= swap_store_ff;
            bank_live_ff   <= bank_store_ff;
        end
    end

    // The stored copies model nonvolatile bits, so system reset leaves them
    always_ff @(posedge clk) begin
        if (done_now && state_ff == flash_seq_pkg::ST_SWAP && !seq_reset) begin
            if (toggle_pend_region_ff)
                swap_store_ff <= ~swap_store_ff;
            else
                bank_store_ff <= ~bank_store_ff;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            toggle_pend_region_ff <= 1'b1;
        else if (go_swap && !seq_reset)
            toggle_pend_region_ff <= toggle_region_swap_flag;
    end

    // Select setting is volatile and acts at once
    wire       sel_wr  = write_region_select && !dual_mode && region_select_in != 2'h3;
    wire [1:0] nxt_sel = sel_wr ? region_select_in : sel_ff;
    wire       nxt_swap_live = live_loaded_ff ? swap_live_ff : swap_store_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            sel_ff <= `SEL_FOLLOW;
        else
            sel_ff <= nxt_sel;
    end

    // Frequency notice; large parts pick a faster data flash read above limit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            freq_ff <= '0;
            fast_ff <= 1'b0;
        end else if (write_clock_freq) begin
            freq_ff <= clock_freq_hz;
            fast_ff <= (clock_freq_hz > `FAST_READ_THRESH_HZ);
        end
    end

    // Next values are used so the region follows a select write in the same edge
    wire region_now = (nxt_sel == `SEL_ZERO) ? 1'b0 :
                      (nxt_sel == `SEL_ONE)  ? 1'b1 : ~nxt_swap_live;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ready_ff   <= 1'b0;
            idle_ff    <= 1'b1;
            refused_ff <= 1'b0;
            start_ff   <= 1'b0;
        end else begin
            ready_ff   <= done_now && !seq_reset;
            idle_ff    <= (nxt_state == flash_seq_pkg::ST_IDLE);
            refused_ff <= pe_bad && !seq_reset;
            start_ff   <= pe_ok && !go_win && !go_swap && !seq_reset;
        end
    end

    assign sequencer_idle        = idle_ff;
    assign flash_ready_irq       = ready_ff;
    assign pe_refused            = refused_ff;
    assign pe_start              = start_ff;
    assign read_protect_window   = win_ff;
    assign window_active         = win_on_ff;
    assign read_region_swap_flag = swap_store_ff;
    assign read_region_select    = sel_ff;
    assign active_startup_region = region_now_ff;
    assign read_startup_bank     = bank_live_ff ? `BANK_ONE_CODE : `BANK_ZERO_CODE;
    assign fast_data_read        = fast_ff;
    assign flash_clock_hz        = freq_ff;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            region_now_ff <= 1'b0;
        else
            region_now_ff <= region_now;
    end
endmodule

// File: flash_sequencer_boot_control_test.sv
// Purpose: self-checking bench for the flash sequencer control block
// Assumes: ten-cycle operations, window end exclusive
// Notes:   nonvolatile flags keep their values across reset, so they are checked against old values
`include "flash_seq_params.svh"
module flash_sequencer_boot_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] b; logic ok; logic [31:0] f; logic fa; logic [1:0] s, es;} row_t;
    logic clk = 1'h0;
    logic reset_n, dual_mode, seq_reset, write_protect_window, toggle_region_swap_flag;
    logic write_region_select, toggle_startup_bank, write_clock_freq, o1, o2;
    logic [1:0] region_select_in, read_region_select;
    logic [`FREQ_W-1:0] clock_freq_hz, flash_clock_hz;
    flash_seq_pkg::window_t window_in, read_protect_window;
    flash_seq_pkg::pe_req_t pe_req;
    logic sequencer_idle, flash_ready_irq, window_active, pe_refused, pe_start;
    logic read_region_swap_flag, active_startup_region, read_startup_bank, fast_data_read;
    int n_mismatch = 0;
    int num_checks = 0;
    // Value 3 is ignored, so the third row keeps the previous setting
    row_t rows [5] = '{'{8'h10, 1, 32'h01C9C380, 0, 2'h1, 2'h1},
                       '{8'h1F, 1, 32'h01C9C381, 1, 2'h2, 2'h2},
                       '{8'h20, 0, 32'h00000000, 0, 2'h3, 2'h2},
                       '{8'h0F, 0, 32'hFFFFFFFF, 1, 2'h1, 2'h1},
                       '{8'hFF, 0, 32'h00F42400, 0, 2'h0, 2'h0}};

    flash_sequencer_boot_control dut (.*);
    always #20 clk = ~clk;

    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tick;
        @(posedge clk);
        #1;
    endtask
    task rst;
        reset_n = 1'h0;
        tick;
        reset_n = 1'h1;
        tick;
    endtask
    task wait_idle;
        for (int i = 0; i < 30 && sequencer_idle !== 1'h1; i++) tick;
    endtask
    task op_done;
        check(sequencer_idle, 1'h0);
        repeat (8) tick;
        check(flash_ready_irq, 1'h0);
        tick;
        check(flash_ready_irq, 1'h1);
        check(sequencer_idle, 1'h1);
        tick;
    endtask
    task win(input logic [7:0] s, input logic [7:0] e);
        window_in = '{s, e};
        write_protect_window = 1'h1;
        tick;
        write_protect_window = 1'h0;
        op_done;
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        {dual_mode, seq_reset, write_protect_window, toggle_region_swap_flag} = 4'h0;
        {write_region_select, toggle_startup_bank, write_clock_freq} = 3'h0;
        reset_n = 1'h0;
        region_select_in = 2'h0;
        clock_freq_hz = '0;
        window_in = '0;
        pe_req = '0;
        repeat (3) tick;
        reset_n = 1'h1;
        check(sequencer_idle, 1'h1);
        check(window_active, 1'h0);
        check(read_region_select, `SEL_FOLLOW);
        win(8'h10, 8'h20);
        check(read_protect_window, 16'h1020);
        foreach (rows[i]) begin
            pe_req = '{1'h1, i[0], rows[i].b};
            clock_freq_hz = rows[i].f;
            region_select_in = rows[i].s;
            {write_clock_freq, write_region_select} = 2'h3;
            tick;
            {pe_req.valid, write_clock_freq, write_region_select} = 3'h0;
            check(pe_start, rows[i].ok);
            check(pe_refused, !rows[i].ok);
            check(flash_clock_hz, rows[i].f);
            check(fast_data_read, rows[i].fa);
            check(read_region_select, rows[i].es);
            if (rows[i].es != 2'h0) check(active_startup_region, rows[i].es == 2'h2);
            wait_idle;
        end
        // A window write while a program runs must be ignored
        pe_req = '{1'h1, 1'h0, 8'h18};
        tick;
        pe_req.valid = 1'h0;
        window_in = '{8'h40, 8'h50};
        write_protect_window = 1'h1;
        tick;
        write_protect_window = 1'h0;
        wait_idle;
        tick;
        check(read_protect_window, 16'h1020);
        write_protect_window = 1'h1;
        tick;
        write_protect_window = 1'h0;
        repeat (3) tick;
        seq_reset = 1'h1;
        tick;
        seq_reset = 1'h0;
        check(sequencer_idle, 1'h1);
        win(8'h30, 8'h30);
        check(window_active, 1'h0);
        o1 = active_startup_region;
        o2 = read_region_swap_flag;
        toggle_region_swap_flag = 1'h1;
        tick;
        toggle_region_swap_flag = 1'h0;
        op_done;
        check(read_region_swap_flag, !o2);
        check(active_startup_region, o1);
        rst;
        check(active_startup_region, !o1);
        check(read_region_select, `SEL_FOLLOW);
        dual_mode = 1'h1;
        o1 = read_startup_bank;
        toggle_startup_bank = 1'h1;
        tick;
        toggle_startup_bank = 1'h0;
        wait_idle;
        check(read_startup_bank, o1);
        rst;
        check(read_startup_bank, !o1);
        test_done;
    end

    initial begin
        #100000;
        n_mismatch++;
        test_done;
    end
endmodule

bind flash_sequencer_boot_control flash_boot_checker chk (.*);
